// *** common/pmbus_margin_map.svh ***
`ifndef PMBUS_MARGIN_MAP_SVH
`define PMBUS_MARGIN_MAP_SVH

// Command codes carried on the interface
`define CMD_OPERATION 8'h01
`define CMD_MARGIN_HIGH 8'h25
`define CMD_MARGIN_LOW 8'h26
`define CMD_TRIM 8'h22
`define CMD_OC_WARN 8'h4A
`define CMD_OV_LIMIT 8'h40
`define CMD_OV_RESP 8'h41
`define CMD_UV_LIMIT 8'h44
`define CMD_UV_RESP 8'h45
`define CMD_VIN_ON 8'h35
`define CMD_VIN_OFF 8'h36
`define CMD_PG_ON 8'h5E
`define CMD_PG_OFF 8'h5F
`define CMD_TEMP_STATUS 8'h7D
`define CMD_STATUS_VOUT 8'h7A
`define CMD_READ_VIN 8'h88
`define CMD_READ_VOUT 8'h8B
`define CMD_READ_IOUT 8'h8C

// Field positions
`define OP_ON_BIT 7
`define OP_MARGIN_HI 5
`define OP_MARGIN_LO 2
`define RESP_MODE_HI 7
`define RESP_MODE_LO 6
`define RESP_RETRY_HI 5
`define RESP_RETRY_LO 3
`define PG_ZERO_BIT 15

// Masks and reset values
`define OC_WARN_MASK 16'hF83F
`define OC_WARN_EXP 16'hF800
`define VIN_MASK 16'hF87F
`define VIN_EXP 16'hF000
`define OC_FIXED_25A 16'hF832
`define PG_ON_RST 16'h046A
`define PG_OFF_RST 16'h0452
`define MARGIN_HI_RST 16'h0000
`define MARGIN_LO_RST 16'h0000
`define OP_RST 8'h80
`define OV_PCT_RST 2'h2
`define UV_PCT_RST 2'h2
`define RESP_RST 8'h80
// VIN mantissa in quarter volts: 2.5 V .. 14 V
`define VIN_MIN_Q 7'h0A
`define VIN_ON_MIN_Q 7'h0B
`define VIN_ON_STEP_Q 7'h0C
`define VIN_MAX_Q 7'h38
`define VIN_ON_RST 16'hF00B
`define VIN_OFF_RST 16'hF00A

// Timing
`define SAMPLE_PERIOD_NS 200000
`define CLK_PERIOD_NS 5
`define SAMPLE_COUNT 16
`define FAULT_DELAY_CYCLES 4

`endif

// *** common/pmbus_margin_pkg.sv ***
package pmbus_margin_pkg;
    typedef enum logic [1:0] {
        MARGIN_OFF = 2'b00,
        MARGIN_LOW = 2'b01,
        MARGIN_HIGH = 2'b10
    } margin_e;

    typedef enum logic [1:0] {
        RESP_CONTINUE = 2'b00,
        RESP_DELAYED = 2'b01,
        RESP_IMMEDIATE = 2'b10,
        RESP_HOLD_OFF = 2'b11
    } resp_e;

    typedef logic [15:0] word_t;
endpackage : pmbus_margin_pkg

// *** common/pmbus_cmd_if.sv ***
`timescale 1ns/1ps
interface pmbus_cmd_if;
    logic cmd_valid;
    logic cmd_write;
    logic [7:0] cmd_code;
    logic [15:0] cmd_wdata;
    logic rsp_valid;
    logic [15:0] rsp_rdata;
    logic power_ok_oe;

    // Open-drain: pulled high unless the device sinks it
    logic power_ok_output;
    assign power_ok_output = ~power_ok_oe;

    modport device (
        input cmd_valid, cmd_write, cmd_code, cmd_wdata,
        output rsp_valid, rsp_rdata, power_ok_oe
    );
    modport host (
        output cmd_valid, cmd_write, cmd_code, cmd_wdata,
        input rsp_valid, rsp_rdata, power_ok_output
    );
endinterface : pmbus_cmd_if

// *** src/pmbus_margin_protect_monitor.sv ***
`timescale 1ns/1ps
`include "pmbus_margin_map.svh"
// Functional notes
// - Margin words linear exp -10, bit15 zero
// - Margined target is margin plus trim
// - Host keeps margin plus trim within 25%
// - Operation bits 5:2 select margin mode
// - OC warn exp -1, six mantissa bits
// - OC warning vs limit, fixed option 25A
// - Temperature status reports fault and warning
// - OV trip 108/110/112/115, default 112
// - UV trip 92/90/88/85, default 88
// - Limit words snap to nearest allowed trip percent
// - Response 00 continues through fault
// - Response 01 waits four cycles, then off
// - Response 10 shuts off immediately
// - Response 11 disables while fault present
// - Turn-on threshold 2.75V or 3..14V
// - Turn-off 2.5..14V, snap to nearest
// - Input threshold exp -2, top four zero
// - Power-ok low on temp, current, regulation
// - Power-ok asserts above lower on window
// - Power-ok deasserts below off window
// - Power-ok words bit15 zero, given defaults
// - Average 16 samples every 200us
// - Operation bit 7 enables output
module pmbus_margin_protect_monitor #(
    parameter int SAMPLE_CYCLES = `SAMPLE_PERIOD_NS / `CLK_PERIOD_NS,
    parameter bit OC_LIMIT_FIXED = 1'b0,
    parameter logic [15:0] NOMINAL_VOUT = 16'h04CD
) (
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic reset_n_i,
    // Host side
    pmbus_cmd_if.device bus,
    // Analog front end, asynchronous
    input wire logic [15:0] adc_vout_i,
    input wire logic [15:0] adc_iout_i,
    input wire logic [15:0] adc_vin_i,
    input wire logic temp_fault_i,
    input wire logic temp_warn_i,
    // Converter control
    output logic output_enable_o,
    output logic [15:0] vout_target_o,
    output logic oc_warning_o,
    output logic vin_ok_o
);
    import pmbus_margin_pkg::*;

    logic [7:0] op_reg, ov_resp_reg, uv_resp_reg;
    logic [15:0] mhi_reg, mlo_reg, trim_reg, oc_reg, von_reg, voff_reg, pgon_reg, pgoff_reg;
    logic [1:0] ov_pct_reg, uv_pct_reg;
    logic [15:0] vout_s1, vout_s2, iout_s1, iout_s2, vin_s1, vin_s2;
    logic [1:0] temp_s1, temp_s2;

    // Percent of v, in 1/1024 fractions
    function automatic logic [15:0] pct(input logic [15:0] v, input logic [10:0] p);
        logic [26:0] prod;
        prod = 27'(v) * 27'(p);
        return prod[25:10];
    endfunction : pct

    // Snap a limit word to the nearest percentage code, midpoints as thresholds
    function automatic logic [1:0] snap(input logic [15:0] w, input logic [15:0] n,
                                        input bit over);
        logic [1:0] code;
        if (over) begin
            code = 2'h0;
            if (w >= pct(n, 11'h45C)) code = 2'h1;
            if (w >= pct(n, 11'h471)) code = 2'h2;
            if (w >= pct(n, 11'h48A)) code = 2'h3;
        end else begin
            code = 2'h3;
            if (w >= pct(n, 11'h376)) code = 2'h2;
            if (w >= pct(n, 11'h38F)) code = 2'h1;
            if (w >= pct(n, 11'h3A4)) code = 2'h0;
        end
        return code;
    endfunction : snap

    // Nearest allowed input threshold in quarter volts
    function automatic logic [15:0] vin_snap(input logic [15:0] w, input bit on);
        logic [10:0] m;
        logic [6:0] q;
        m = w[10:0];
        if (m > 11'(`VIN_MAX_Q)) q = `VIN_MAX_Q;
        else q = m[6:0];
        if (q < `VIN_MIN_Q) q = `VIN_MIN_Q;
        if (on && q < `VIN_ON_STEP_Q) begin
            q = (q == `VIN_MIN_Q) ? `VIN_ON_MIN_Q : q;
        end else if (q[0]) begin
            q = q + 7'h1;
        end
        return `VIN_EXP | 16'(q);
    endfunction : vin_snap

    function automatic logic [15:0] ov_lvl(input logic [1:0] c, input logic [15:0] n);
        unique case (c)
            2'h0: return pct(n, 11'd1106);
            2'h1: return pct(n, 11'd1126);
            2'h2: return pct(n, 11'd1147);
            2'h3: return pct(n, 11'd1178);
        endcase
    endfunction : ov_lvl

    function automatic logic [15:0] uv_lvl(input logic [1:0] c, input logic [15:0] n);
        unique case (c)
            2'h0: return pct(n, 11'd942);
            2'h1: return pct(n, 11'd922);
            2'h2: return pct(n, 11'd901);
            2'h3: return pct(n, 11'd870);
        endcase
    endfunction : uv_lvl

    // Host command writes
    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            op_reg <= `OP_RST;
            mhi_reg <= `MARGIN_HI_RST;
            mlo_reg <= `MARGIN_LO_RST;
            trim_reg <= 16'h0000;
            oc_reg <= `OC_FIXED_25A;
            ov_pct_reg <= `OV_PCT_RST;
            uv_pct_reg <= `UV_PCT_RST;
            ov_resp_reg <= `RESP_RST;
            uv_resp_reg <= `RESP_RST;
            von_reg <= `VIN_ON_RST;
            voff_reg <= `VIN_OFF_RST;
            pgon_reg <= `PG_ON_RST;
            pgoff_reg <= `PG_OFF_RST;
        end else if (bus.cmd_valid && bus.cmd_write) begin
            unique case (bus.cmd_code)
                `CMD_OPERATION: op_reg <= bus.cmd_wdata[7:0];
                `CMD_MARGIN_HIGH: mhi_reg <= bus.cmd_wdata & 16'h7FFF;
                `CMD_MARGIN_LOW: mlo_reg <= bus.cmd_wdata & 16'h7FFF;
                `CMD_TRIM: trim_reg <= bus.cmd_wdata;
                `CMD_OC_WARN: oc_reg <= OC_LIMIT_FIXED ? `OC_FIXED_25A :
                                        ((bus.cmd_wdata & `OC_WARN_MASK) | `OC_WARN_EXP);
                `CMD_OV_LIMIT: ov_pct_reg <= snap(bus.cmd_wdata, NOMINAL_VOUT, 1'b1);
                `CMD_UV_LIMIT: uv_pct_reg <= snap(bus.cmd_wdata, NOMINAL_VOUT, 1'b0);
                `CMD_OV_RESP: ov_resp_reg <= bus.cmd_wdata[7:0];
                `CMD_UV_RESP: uv_resp_reg <= bus.cmd_wdata[7:0];
                `CMD_VIN_ON: von_reg <= vin_snap(bus.cmd_wdata, 1'b1);
                `CMD_VIN_OFF: voff_reg <= vin_snap(bus.cmd_wdata, 1'b0);
                `CMD_PG_ON: pgon_reg <= bus.cmd_wdata & 16'h7FFF;
                `CMD_PG_OFF: pgoff_reg <= bus.cmd_wdata & 16'h7FFF;
                default: ;
            endcase
        end
    end

    // Two-stage synchronisers on analog inputs
    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            {vout_s1, vout_s2, iout_s1, iout_s2, vin_s1, vin_s2} <= '0;
            {temp_s1, temp_s2} <= '0;
        end else begin
            vout_s1 <= adc_vout_i;
            vout_s2 <= vout_s1;
            iout_s1 <= adc_iout_i;
            iout_s2 <= iout_s1;
            vin_s1 <= adc_vin_i;
            vin_s2 <= vin_s1;
            temp_s1 <= {temp_fault_i, temp_warn_i};
            temp_s2 <= temp_s1;
        end
    end

    logic [31:0] period_cnt;
    logic [4:0] samp_cnt;
    logic [19:0] acc_v, acc_i, acc_n;
    logic [15:0] avg_v, avg_i, avg_n;
    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            period_cnt <= '0;
            samp_cnt <= '0;
            {acc_v, acc_i, acc_n} <= '0;
            {avg_v, avg_i, avg_n} <= '0;
        end else if (samp_cnt != 5'h0) begin
            acc_v <= acc_v + 20'(vout_s2);
            acc_i <= acc_i + 20'(iout_s2);
            acc_n <= acc_n + 20'(vin_s2);
            samp_cnt <= samp_cnt - 5'h1;
            period_cnt <= period_cnt + 32'h1;
            if (samp_cnt == 5'h1) begin
                avg_v <= 16'((acc_v + 20'(vout_s2)) >> 4);
                avg_i <= 16'((acc_i + 20'(iout_s2)) >> 4);
                avg_n <= 16'((acc_n + 20'(vin_s2)) >> 4);
            end
        end else if (period_cnt >= 32'(SAMPLE_CYCLES - 1)) begin
            period_cnt <= '0;
            samp_cnt <= 5'(`SAMPLE_COUNT);
            {acc_v, acc_i, acc_n} <= '0;
        end else begin
            period_cnt <= period_cnt + 32'h1;
        end
    end

    margin_e margin;
    logic act_on_fault;
    always_comb begin
        margin = MARGIN_OFF;
        act_on_fault = 1'b1;
        unique case (op_reg[`OP_MARGIN_HI:`OP_MARGIN_LO])
            4'b0101: begin margin = MARGIN_LOW; act_on_fault = 1'b0; end
            4'b0110: margin = MARGIN_LOW;
            4'b1001: begin margin = MARGIN_HIGH; act_on_fault = 1'b0; end
            4'b1010: margin = MARGIN_HIGH;
            default: ;
        endcase
    end

    // target word; range left to host
    logic [15:0] target;
    always_comb begin
        unique case (margin)
            MARGIN_LOW: target = mlo_reg + trim_reg;
            MARGIN_HIGH: target = mhi_reg + trim_reg;
            default: target = NOMINAL_VOUT + trim_reg;
        endcase
    end

    logic ov_now, uv_now;
    assign ov_now = avg_v > ov_lvl(ov_pct_reg, target);
    assign uv_now = avg_v < uv_lvl(uv_pct_reg, target);

    // fault responses, one engine per fault
    logic [1:0] off_req;
    logic [2:0] dly_cnt [2];
    logic [1:0] latched;
    for (genvar k = 0; k < 2; k++) begin : g_resp
        logic flt;
        logic [7:0] rb;
        assign flt = (k == 0 ? ov_now : uv_now) && act_on_fault;
        assign rb = (k == 0) ? ov_resp_reg : uv_resp_reg;
        always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
            if (!reset_n_i) begin
                dly_cnt[k] <= '0;
                latched[k] <= 1'b0;
            end else if (!op_reg[`OP_ON_BIT]) begin
                dly_cnt[k] <= '0;
                latched[k] <= 1'b0;
            end else if (!flt) begin
                dly_cnt[k] <= '0;
                if (rb[`RESP_RETRY_HI:`RESP_RETRY_LO] == 3'b111) latched[k] <= 1'b0;
            end else if (rb[`RESP_MODE_HI:`RESP_MODE_LO] == RESP_IMMEDIATE) begin
                latched[k] <= 1'b1;
            end else if (rb[`RESP_MODE_HI:`RESP_MODE_LO] == RESP_DELAYED) begin
                if (dly_cnt[k] == 3'(`FAULT_DELAY_CYCLES - 1)) latched[k] <= 1'b1;
                else dly_cnt[k] <= dly_cnt[k] + 3'h1;
            end
        end
        assign off_req[k] = latched[k] ||
            (flt && rb[`RESP_MODE_HI:`RESP_MODE_LO] == RESP_HOLD_OFF);
    end

    logic pg_reg;
    logic [15:0] dev;
    assign dev = (avg_v > target) ? avg_v - target : target - avg_v;
    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            pg_reg <= 1'b0;
        end else if (temp_s2[1] || oc_warning_o || !output_enable_o ||
                     dev > NOMINAL_VOUT - pgoff_reg) begin
            pg_reg <= 1'b0;
        end else if (dev < NOMINAL_VOUT - pgon_reg) begin
            pg_reg <= 1'b1;
        end
    end

    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            output_enable_o <= 1'b0;
            vout_target_o <= '0;
            oc_warning_o <= 1'b0;
            vin_ok_o <= 1'b0;
            bus.power_ok_oe <= 1'b1;
        end else begin
            output_enable_o <= op_reg[`OP_ON_BIT] && vin_ok_o && off_req == 2'b00;
            vout_target_o <= target;
            oc_warning_o <= avg_i[10:0] > {oc_reg[5:0], 5'h00};
            if (avg_n[10:0] >= {von_reg[6:0], 4'h0}) vin_ok_o <= 1'b1;
            else if (avg_n[10:0] < {voff_reg[6:0], 4'h0}) vin_ok_o <= 1'b0;
            bus.power_ok_oe <= !pg_reg;
        end
    end

    // Read answers, temperature status
    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            bus.rsp_valid <= 1'b0;
            bus.rsp_rdata <= '0;
        end else begin
            bus.rsp_valid <= bus.cmd_valid && !bus.cmd_write;
            unique case (bus.cmd_code)
                `CMD_OPERATION: bus.rsp_rdata <= {8'h00, op_reg};
                `CMD_MARGIN_HIGH: bus.rsp_rdata <= mhi_reg;
                `CMD_MARGIN_LOW: bus.rsp_rdata <= mlo_reg;
                `CMD_TRIM: bus.rsp_rdata <= trim_reg;
                `CMD_OC_WARN: bus.rsp_rdata <= oc_reg;
                `CMD_OV_LIMIT: bus.rsp_rdata <= ov_lvl(ov_pct_reg, NOMINAL_VOUT);
                `CMD_UV_LIMIT: bus.rsp_rdata <= uv_lvl(uv_pct_reg, NOMINAL_VOUT);
                `CMD_OV_RESP: bus.rsp_rdata <= {8'h00, ov_resp_reg};
                `CMD_UV_RESP: bus.rsp_rdata <= {8'h00, uv_resp_reg};
                `CMD_VIN_ON: bus.rsp_rdata <= von_reg;
                `CMD_VIN_OFF: bus.rsp_rdata <= voff_reg;
                `CMD_PG_ON: bus.rsp_rdata <= pgon_reg;
                `CMD_PG_OFF: bus.rsp_rdata <= pgoff_reg;
                `CMD_TEMP_STATUS: bus.rsp_rdata <= {8'h00, temp_s2[1], temp_s2[0], 6'h00};
                `CMD_STATUS_VOUT: bus.rsp_rdata <= {8'h00, latched[0], 2'b00, latched[1], 4'h0};
                `CMD_READ_VOUT: bus.rsp_rdata <= avg_v;
                `CMD_READ_IOUT: bus.rsp_rdata <= avg_i;
                `CMD_READ_VIN: bus.rsp_rdata <= avg_n;
                default: bus.rsp_rdata <= 16'h0000;
            endcase
        end
    end
endmodule : pmbus_margin_protect_monitor

// *** src/pmbus_host_ctrl.sv ***
`timescale 1ns/1ps
`include "pmbus_margin_map.svh"
module pmbus_host_ctrl (
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic reset_n_i,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Device side
    pmbus_cmd_if.host dev
);
    import pmbus_margin_pkg::*;

    localparam logic [3:0] ADR_CMD = 4'h0;
    localparam logic [3:0] ADR_DATA = 4'h4;
    localparam logic [3:0] ADR_STAT = 4'h8;

    logic busy_reg, pok_s1, pok_s2;
    logic [15:0] rdata_reg;

    // Device replies one cycle after a read; writes need no reply
    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            dev.cmd_valid <= 1'b0;
            dev.cmd_write <= 1'b0;
            dev.cmd_code <= '0;
            dev.cmd_wdata <= '0;
            busy_reg <= 1'b0;
            rdata_reg <= '0;
        end else begin
            dev.cmd_valid <= 1'b0;
            if (dev.rsp_valid) begin
                rdata_reg <= dev.rsp_rdata;
                busy_reg <= 1'b0;
            end
            if (wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_adr_i == ADR_DATA) begin
                dev.cmd_wdata <= wb_dat_i[15:0];
            end
            if (wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_adr_i == ADR_CMD &&
                wb_sel_i[0] && !busy_reg) begin
                // field forcing is done by the device
                dev.cmd_valid <= 1'b1;
                dev.cmd_write <= wb_dat_i[8];
                dev.cmd_code <= wb_dat_i[7:0];
                busy_reg <= !wb_dat_i[8];
            end
        end
    end

    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            pok_s1 <= 1'b0;
            pok_s2 <= 1'b0;
        end else begin
            pok_s1 <= dev.power_ok_output;
            pok_s2 <= pok_s1;
        end
    end

    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= '0;
        end else begin
            wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
            unique case (wb_adr_i)
                ADR_DATA: wb_dat_o <= {16'h0000, rdata_reg};
                ADR_STAT: wb_dat_o <= {30'h0, pok_s2, busy_reg};
                default: wb_dat_o <= 32'h0000_0000;
            endcase
        end
    end
endmodule : pmbus_host_ctrl

// *** tb/pmbus_link_chk.sv ***
`timescale 1ns/1ps
`include "pmbus_margin_map.svh"
module pmbus_link_chk (
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic reset_n_i,
    // Command link
    input wire logic cmd_valid,
    input wire logic cmd_write,
    input wire logic [7:0] cmd_code,
    input wire logic [15:0] cmd_wdata,
    input wire logic rsp_valid,
    input wire logic [15:0] rsp_rdata,
    input wire logic power_ok_oe,
    input wire logic power_ok_output
);
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!reset_n_i);

    read_answer_a: assert property (cmd_valid && !cmd_write |=> rsp_valid)
        else $error("read not answered in the next cycle");
    answer_cause_a: assert property (rsp_valid |-> $past(cmd_valid) && !$past(cmd_write))
        else $error("answer without a read");
    margin_msb_a: assert property (rsp_valid && $past(cmd_code) inside
        {`CMD_MARGIN_HIGH, `CMD_MARGIN_LOW} |-> !rsp_rdata[15])
        else $error("margin word top bit set");
    oc_format_a: assert property (rsp_valid && $past(cmd_code) == `CMD_OC_WARN
        |-> rsp_rdata[15:11] == 5'h1F && rsp_rdata[10:6] == 5'h00)
        else $error("warn limit format wrong");
    vin_format_a: assert property (rsp_valid && $past(cmd_code) inside
        {`CMD_VIN_ON, `CMD_VIN_OFF} |-> rsp_rdata[15:7] == 9'h1E0)
        else $error("input threshold format wrong");
    vin_on_set_a: assert property (rsp_valid && $past(cmd_code) == `CMD_VIN_ON
        |-> rsp_rdata[6:0] == 7'h0B || (!rsp_rdata[0] && rsp_rdata[6:0] inside {[7'h0C:7'h38]}))
        else $error("turn-on threshold not allowed");
    vin_off_set_a: assert property (rsp_valid && $past(cmd_code) == `CMD_VIN_OFF
        |-> !rsp_rdata[0] && rsp_rdata[6:0] inside {[7'h0A:7'h38]})
        else $error("turn-off threshold not allowed");
    pg_msb_a: assert property (rsp_valid && $past(cmd_code) inside
        {`CMD_PG_ON, `CMD_PG_OFF} |-> !rsp_rdata[15])
        else $error("power-ok word top bit set");
endmodule : pmbus_link_chk

// *** tb/tb.sv ***
`timescale 1ns/1ps
`include "pmbus_margin_map.svh"
module tb;
    import pmbus_margin_pkg::*;
    localparam int NOM = 1229;
    logic sys_clk_i = 1'b0;
    logic reset_n_i = 1'b0;
    logic wb_cyc = 1'b0;
    logic wb_stb = 1'b0;
    logic wb_we = 1'b0;
    logic [3:0] wb_adr = 4'h0;
    logic [31:0] wb_wr = 32'h0;
    logic [31:0] wb_rd;
    logic wb_ack;
    logic [15:0] vout = 16'h04CD;
    logic [15:0] iout = 16'h0000;
    logic [15:0] vin = 16'h3FFF;
    logic t_fault = 1'b0;
    logic t_warn = 1'b0;
    logic en, oc_w, vin_ok;
    logic [15:0] target, rd, v;
    logic [15:0] tr [3];
    logic [15:0] mdl [int];
    logic [6:0] m;
    logic [31:0] st;
    logic [7:0] ops [7] = '{8'h80, 8'h84, 8'h8C, 8'h94, 8'h98, 8'hA4, 8'hA8};
    logic [7:0] resp [6] = '{8'h00, 8'h40, 8'h80, 8'h78, 8'hB8, 8'hC0};
    logic ef [6] = '{1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0};
    logic ea [6] = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1};
    int ovp [5] = '{112, 108, 110, 112, 115};
    int uvp [5] = '{88, 92, 90, 88, 85};
    int n_errors = 0;
    int tests_run = 0;
    int cycles = 0;
    int t, e;

    always #2.5 sys_clk_i = ~sys_clk_i;

    pmbus_cmd_if bus ();
    pmbus_host_ctrl i_pmbus_host_ctrl (.sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i),
        .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr),
        .wb_sel_i(4'hF), .wb_dat_i(wb_wr), .wb_dat_o(wb_rd), .wb_ack_o(wb_ack), .dev(bus));
    pmbus_margin_protect_monitor #(.SAMPLE_CYCLES(64), .NOMINAL_VOUT(16'h04CD))
        i_pmbus_margin_protect_monitor (.sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i),
        .bus(bus), .adc_vout_i(vout), .adc_iout_i(iout), .adc_vin_i(vin),
        .temp_fault_i(t_fault), .temp_warn_i(t_warn), .output_enable_o(en),
        .vout_target_o(target), .oc_warning_o(oc_w), .vin_ok_o(vin_ok));
    pmbus_link_chk i_chk (.sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i),
        .cmd_valid(bus.cmd_valid), .cmd_write(bus.cmd_write), .cmd_code(bus.cmd_code),
        .cmd_wdata(bus.cmd_wdata), .rsp_valid(bus.rsp_valid), .rsp_rdata(bus.rsp_rdata),
        .power_ok_oe(bus.power_ok_oe), .power_ok_output(bus.power_ok_output));

    task automatic complete_run();
        $display("checks %0d mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : complete_run

    task automatic chk(string nm, logic [15:0] x, logic [15:0] g);
        tests_run++;
        if (g !== x) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", nm, x, g);
        end
    endtask : chk

    // Holds the request until ack is sampled high, then releases
    task automatic wb(logic we, logic [3:0] a, logic [31:0] d, output logic [31:0] q);
        @(posedge sys_clk_i);
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= we;
        wb_adr <= a;
        wb_wr <= d;
        do @(posedge sys_clk_i); while (wb_ack !== 1'b1);
        q = wb_rd;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
    endtask : wb

    task automatic put(logic [7:0] c, logic [15:0] d);
        logic [31:0] q;
        wb(1'b1, 4'h4, {16'h0, d}, q);
        wb(1'b1, 4'h0, {23'h0, 1'b1, c}, q);
        repeat (3) @(posedge sys_clk_i);
    endtask : put

    task automatic get(logic [7:0] c, output logic [15:0] r);
        logic [31:0] q;
        int n;
        wb(1'b1, 4'h0, {24'h0, c}, q);
        n = 0;
        q = 32'h1;
        while (q[0] !== 1'b0 && n < 50) begin
            wb(1'b0, 4'h8, 32'h0, q);
            n++;
        end
        wb(1'b0, 4'h4, 32'h0, q);
        r = q[15:0];
    endtask : get

    task automatic settle();
        repeat (2100) @(posedge sys_clk_i);
    endtask : settle

    task automatic check_all();
        foreach (mdl[c]) begin
            get(8'(c), rd);
            chk($sformatf("readback %h", c), mdl[c], rd);
        end
    endtask : check_all

    // Cuts a hang short
    always @(posedge sys_clk_i) begin
        cycles++;
        if (cycles == 90000) begin
            n_errors++;
            complete_run();
        end
    end

    initial begin
        v = 16'($urandom(54));
        repeat (5) @(posedge sys_clk_i);
        reset_n_i <= 1'b1;
        mdl[`CMD_PG_ON] = `PG_ON_RST;
        mdl[`CMD_PG_OFF] = `PG_OFF_RST;
        mdl[`CMD_VIN_ON] = `VIN_ON_RST;
        mdl[`CMD_VIN_OFF] = `VIN_OFF_RST;
        mdl[`CMD_MARGIN_HIGH] = 16'h0000;
        mdl[`CMD_MARGIN_LOW] = 16'h0000;
        check_all();
        // First pass writes out-of-range thresholds, later ones legal even steps
        for (int i = 0; i < 5; i++) begin
            v = 16'($urandom);
            m = i ? 7'(12 + 2 * ($urandom % 23)) : 7'h00;
            put(`CMD_MARGIN_HIGH, v);
            mdl[`CMD_MARGIN_HIGH] = v & 16'h7FFF;
            put(`CMD_MARGIN_LOW, ~v);
            mdl[`CMD_MARGIN_LOW] = ~v & 16'h7FFF;
            put(`CMD_OC_WARN, v);
            mdl[`CMD_OC_WARN] = (v & 16'h003F) | 16'hF800;
            put(`CMD_PG_ON, v);
            mdl[`CMD_PG_ON] = v & 16'h7FFF;
            put(`CMD_PG_OFF, ~v);
            mdl[`CMD_PG_OFF] = ~v & 16'h7FFF;
            put(`CMD_VIN_ON, {9'h1E0, m});
            mdl[`CMD_VIN_ON] = i ? {9'h1E0, m} : 16'hF00B;
            put(`CMD_VIN_OFF, {9'h1E0, i ? m : 7'h7F});
            mdl[`CMD_VIN_OFF] = i ? {9'h1E0, m} : 16'hF038;
            check_all();
        end
        // Trim kept small so margin plus trim stays inside the window
        t = $urandom % 32;
        put(`CMD_TRIM, 16'(t));
        put(`CMD_MARGIN_HIGH, 16'(NOM + 60));
        put(`CMD_MARGIN_LOW, 16'(NOM - 60));
        foreach (ops[k]) begin
            put(`CMD_OPERATION, {8'h0, ops[k]});
            e = ops[k][5:4] == 2'b01 ? NOM - 60 : ops[k][5:4] == 2'b10 ? NOM + 60 : NOM;
            chk("target", 16'(e + t), target);
        end
        put(`CMD_OPERATION, 16'h0080);
        for (int j = 0; j < 2; j++) begin
            for (int k = 0; k < 5; k++) begin
                e = NOM * (j ? uvp[k] : ovp[k]) / 100;
                if (k > 0) put(j ? `CMD_UV_LIMIT : `CMD_OV_LIMIT, 16'(e + $urandom % 7 - 3));
                get(j ? `CMD_UV_LIMIT : `CMD_OV_LIMIT, rd);
                chk("limit snap", 16'h1, 16'(rd >= e - 1 && rd <= e + 1));
            end
        end
        put(`CMD_PG_ON, `PG_ON_RST);
        put(`CMD_PG_OFF, `PG_OFF_RST);
        foreach (resp[k]) begin
            put(k % 2 ? `CMD_OV_RESP : `CMD_UV_RESP, {8'h0, resp[k]});
            put(k % 2 ? `CMD_UV_RESP : `CMD_OV_RESP, 16'h0000);
            put(`CMD_OPERATION, 16'h0000);
            chk("enable cleared", 16'h0, en);
            put(`CMD_OPERATION, 16'h0080);
            settle();
            chk("enable set", 16'h1, en);
            chk("power ok", 16'h1, bus.power_ok_output);
            vout <= k % 2 ? 16'(NOM + 300) : 16'(NOM - 200);
            settle();
            chk("enable in fault", 16'(ef[k]), en);
            chk("power ok fault", 16'h0, bus.power_ok_output);
            vout <= 16'(NOM);
            settle();
            chk("enable after", 16'(ea[k]), en);
        end
        for (int k = 0; k < 3; k++) begin
            t_fault <= k == 1;
            t_warn <= k == 2;
            repeat (200) @(posedge sys_clk_i);
            chk("power ok temp", 16'(k != 1), bus.power_ok_output);
            get(`CMD_TEMP_STATUS, tr[k]);
        end
        chk("temp idle", 16'h0, tr[0]);
        chk("temp split", 16'h1, 16'(tr[1] != 0 && tr[2] != 0 && tr[1] != tr[2]));
        put(`CMD_OC_WARN, 16'hF801);
        iout <= 16'h3FFF;
        settle();
        chk("oc warning", 16'h1, oc_w);
        iout <= 16'h0000;
        settle();
        chk("oc clear", 16'h0, oc_w);
        vin <= 16'h0000;
        settle();
        chk("vin low", 16'h0, vin_ok);
        chk("enable vin low", 16'h0, en);
        vin <= 16'h3FFF;
        settle();
        chk("vin high", 16'h1, vin_ok);
        get(8'hEE, rd);
        chk("unknown code", 16'h0, rd);
        get(`CMD_READ_VOUT, rd);
        chk("average vout", 16'(NOM), rd);
        wb(1'b0, 4'h8, 32'h0, st);
        chk("status word", 16'h0002, st[15:0]);
        complete_run();
    end
endmodule : tb
